// ### cca_consts.svh
// register offsets, field positions and reset values for the capture/compare array
`ifndef CCA_CONSTS_SVH
`define CCA_CONSTS_SVH
`define CCA_ADDR_W 12
`define CCA_OFF_MODE1 12'h492
`define CCA_OFF_MODE2 12'h493
`define CCA_OFF_MODE3 12'h494
`define CCA_OFF_CTRL 12'h4A0
`define CCA_OFF_FLAGS 12'h4A1
`define CCA_OFF_CNTL 12'h4A2
`define CCA_OFF_CNTH 12'h4A3
`define CCA_OFF_CAPL 12'h4B0
`define CCA_OFF_CAPH 12'h4B8
`define CCA_MODE_RST 8'h00
`define CCA_B_ECOM 6
`define CCA_B_CAPP 5
`define CCA_B_CAPN 4
`define CCA_B_MAT 3
`define CCA_B_TOG 2
`define CCA_B_PWM 1
`define CCA_B_ECCF 0
`define CCA_B_RUN 6
`define CCA_MODE_MASK 8'h7F
`define CCA_B_RSVD 7
`define CCA_PWM_WRAP 8'hFF
`endif

// ### cca_pin_model.sv
// external signal source on the module pins
`timescale 1ns/10ps
module cca_pin_model #(
	parameter int N = 3
) (
	input wire logic clk_i,
	input wire logic [N-1:0] oe_i,
	input wire logic [N-1:0] drv_i,
	output logic [N-1:0] pin_o
);
	logic [N-1:0] ext_ff = '0;
	// the device drive wins wherever its enable is high
	assign pin_o = (oe_i & drv_i) | (~oe_i & ext_ff);
	task automatic set_pin(input int i, input logic v);
		@(posedge clk_i);
		ext_ff[i] <= v;
	endtask
endmodule

// ### cca_pkg.sv
// types shared by the capture/compare array
package cca_pkg;
	typedef enum logic [2:0] {
		CCA_IDLE,
		CCA_CAPTURE,
		CCA_TIMER,
		CCA_HSO,
		CCA_PWM
	} cca_func_t;
endpackage

// ### cca_top.sv
// capture/compare modules on a shared 16-bit free-running counter
//
// Functional notes
// R1: rise-only capture latches the counter on each rising pin edge
// R2: fall-only capture latches the counter on each falling pin edge
// R3: both capture bits set latches on any pin transition
// R4: software must set at least one capture edge bit for capture
// R5: pin input is synchronised and sampled for selected transitions
// R6: capture copies counter high and low bytes into capture registers
// R7: interrupt requested only while event flag and its enable are set
// R8: software timer needs comparator and match bits, others clear
// R9: timer compares counter with compare register, match sets flag
// R10: comparator, match, toggle set: pin inverts on every match
// R11: pulse-width and comparator bits drive an 8-bit pwm pin
// R12: software must not write ones to reserved mode bits
// R13: reserved bits read with no fixed level required
// R14: event flags set by hardware, cleared only by software
// R15: all mode bits zero means no capture, compare or pin action
// R16: mode registers reset to zero, bit 7 reserved
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`include "cca_consts.svh"
module cca_top #(
	parameter int NMOD = 3
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [11:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [NMOD-1:0] module_io_pin_i,
	output logic [NMOD-1:0] module_io_pin_o,
	output logic [NMOD-1:0] module_io_pin_oe_o,
	output logic irq_o
);
	// flag register and capture offsets leave room for eight modules
	if (NMOD < 1 || NMOD > 8) begin : g_nmod_chk
		$error("NMOD must be 1..8");
	end

	function automatic cca_pkg::cca_func_t decode(input logic [7:0] m);
		if (m[`CCA_B_CAPP] || m[`CCA_B_CAPN])
			return cca_pkg::CCA_CAPTURE;
		else if (m[`CCA_B_ECOM] && m[`CCA_B_PWM])
			return cca_pkg::CCA_PWM;
		else if (m[`CCA_B_ECOM] && m[`CCA_B_MAT] && m[`CCA_B_TOG])
			return cca_pkg::CCA_HSO;
		else if (m[`CCA_B_ECOM] && m[`CCA_B_MAT])
			return cca_pkg::CCA_TIMER;
		else
			return cca_pkg::CCA_IDLE;
	endfunction

	logic [7:0] mode_ff [NMOD];
	logic [7:0] capl_ff [NMOD];
	logic [7:0] caph_ff [NMOD];
	logic [7:0] pwmref_ff [NMOD];
	logic [NMOD-1:0] flag_ff, pin_ff, sy1_ff, sy2_ff, prev_ff;
	logic run_ff;
	logic [15:0] cnt_ff;
	logic [7:0] rdata_ff;
	logic irq_ff;
	logic [7:0] nxt_mode [NMOD];
	logic [7:0] nxt_capl [NMOD];
	logic [7:0] nxt_caph [NMOD];
	logic [7:0] nxt_pwmref [NMOD];
	logic [NMOD-1:0] nxt_flag, nxt_pin, ev, oe, ie_en;
	logic nxt_run;
	logic [15:0] nxt_cnt;
	logic [7:0] nxt_rdata;
	logic nxt_irq;

	// counter and control
	always_comb begin
		nxt_run = run_ff;
		nxt_cnt = run_ff ? cnt_ff + 16'h0001 : cnt_ff;
		if (wr_i && addr_i == `CCA_OFF_CTRL)
			nxt_run = wdata_i[`CCA_B_RUN];
		if (wr_i && addr_i == `CCA_OFF_CNTL)
			nxt_cnt[7:0] = wdata_i;
		else if (wr_i && addr_i == `CCA_OFF_CNTH)
			nxt_cnt[15:8] = wdata_i;
	end

	// per-module function
	always_comb begin
		for (int i = 0; i < NMOD; i++) begin
			logic rise, fall, match, hit;
			cca_pkg::cca_func_t f;
			f = decode(mode_ff[i]);
			rise = sy2_ff[i] && !prev_ff[i];
			fall = !sy2_ff[i] && prev_ff[i];
			match = run_ff && cnt_ff == {caph_ff[i], capl_ff[i]};
			hit = 1'b0;
			nxt_mode[i] = mode_ff[i];
			nxt_capl[i] = capl_ff[i];
			nxt_caph[i] = caph_ff[i];
			nxt_pwmref[i] = pwmref_ff[i];
			nxt_pin[i] = pin_ff[i];
			oe[i] = 1'b0;
			case (f)
			cca_pkg::CCA_CAPTURE: begin
				// R5
				if ((mode_ff[i][`CCA_B_CAPP] && rise) || // R1 R3
				    (mode_ff[i][`CCA_B_CAPN] && fall)) begin // R2 R3
					hit = 1'b1;
					nxt_capl[i] = cnt_ff[7:0]; // R6
					nxt_caph[i] = cnt_ff[15:8]; // R6
				end
			end
			cca_pkg::CCA_TIMER: begin
				hit = match; // R9
			end
			cca_pkg::CCA_HSO: begin
				oe[i] = 1'b1;
				hit = match;
				if (match)
					nxt_pin[i] = !pin_ff[i]; // R10
			end
			cca_pkg::CCA_PWM: begin
				oe[i] = 1'b1;
				// R11
				nxt_pin[i] = cnt_ff[7:0] >= pwmref_ff[i];
				if (run_ff && cnt_ff[7:0] == `CCA_PWM_WRAP)
					nxt_pwmref[i] = caph_ff[i];
			end
			default: begin
				hit = 1'b0; // R15
			end
			endcase
			ev[i] = hit;
			if (wr_i && addr_i == `CCA_OFF_MODE1 + 12'(i))
				nxt_mode[i] = wdata_i & `CCA_MODE_MASK; // R13
			if (wr_i && addr_i == `CCA_OFF_CAPL + 12'(i))
				nxt_capl[i] = wdata_i;
			if (wr_i && addr_i == `CCA_OFF_CAPH + 12'(i))
				nxt_caph[i] = wdata_i;
			if (wr_i && addr_i == `CCA_OFF_CAPL + 12'(i) && f != cca_pkg::CCA_PWM)
				nxt_pwmref[i] = wdata_i;
		end
	end

	// flags: set wins over the write-one clear
	always_comb begin
		nxt_flag = flag_ff;
		if (wr_i && addr_i == `CCA_OFF_FLAGS)
			nxt_flag = flag_ff & ~wdata_i[NMOD-1:0];
		nxt_flag = nxt_flag | ev; // R14
		for (int i = 0; i < NMOD; i++)
			ie_en[i] = mode_ff[i][`CCA_B_ECCF];
		nxt_irq = |(nxt_flag & ie_en); // R7
	end

	// read mux, data one cycle after the strobe
	always_comb begin
		nxt_rdata = 8'h00;
		if (rd_i) begin
			if (addr_i == `CCA_OFF_CTRL)
				nxt_rdata = {1'b0, run_ff, 6'h00};
			else if (addr_i == `CCA_OFF_FLAGS)
				nxt_rdata = 8'(flag_ff);
			else if (addr_i == `CCA_OFF_CNTL)
				nxt_rdata = cnt_ff[7:0];
			else if (addr_i == `CCA_OFF_CNTH)
				nxt_rdata = cnt_ff[15:8];
			else begin
				for (int i = 0; i < NMOD; i++) begin
					if (addr_i == `CCA_OFF_MODE1 + 12'(i))
						nxt_rdata = mode_ff[i];
					else if (addr_i == `CCA_OFF_CAPL + 12'(i))
						nxt_rdata = capl_ff[i];
					else if (addr_i == `CCA_OFF_CAPH + 12'(i))
						nxt_rdata = caph_ff[i];
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < NMOD; i++) begin
				mode_ff[i] <= `CCA_MODE_RST; // R16
				capl_ff[i] <= 8'h00;
				caph_ff[i] <= 8'h00;
				pwmref_ff[i] <= 8'h00;
			end
			flag_ff <= '0;
			pin_ff <= '0;
			sy1_ff <= '0;
			sy2_ff <= '0;
			prev_ff <= '0;
			run_ff <= 1'b0;
			cnt_ff <= 16'h0000;
			rdata_ff <= 8'h00;
			irq_ff <= 1'b0;
			module_io_pin_oe_o <= '0;
		end else begin
			mode_ff <= nxt_mode;
			capl_ff <= nxt_capl;
			caph_ff <= nxt_caph;
			pwmref_ff <= nxt_pwmref;
			flag_ff <= nxt_flag;
			pin_ff <= nxt_pin;
			sy1_ff <= module_io_pin_i; // R5
			sy2_ff <= sy1_ff;
			prev_ff <= sy2_ff;
			run_ff <= nxt_run;
			cnt_ff <= nxt_cnt;
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
			module_io_pin_oe_o <= oe;
		end
	end

	assign rdata_o = rdata_ff;
	assign module_io_pin_o = pin_ff;
	assign irq_o = irq_ff;

	sequence rise_seen(int k);
		!prev_ff[k] && sy2_ff[k];
	endsequence

	sequence fall_seen(int k);
		prev_ff[k] && !sy2_ff[k];
	endsequence

	irq_gate_a: assert property (@(posedge clk_i) // R7
		disable iff (!rstn_i)
		irq_o == |(flag_ff & $past(ie_en)))
		else $error("irq mismatch");
	read_idle_a: assert property (@(posedge clk_i)
		disable iff (!rstn_i)
		!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside read slot");

	for (genvar k = 0; k < NMOD; k++) begin : g_chk
		capture_rise_a: assert property (@(posedge clk_i) // R1
			disable iff (!rstn_i)
			((decode(mode_ff[k]) == cca_pkg::CCA_CAPTURE
			&& mode_ff[k][`CCA_B_CAPP]) and rise_seen(k))
			|=> {caph_ff[k], capl_ff[k]} == $past(cnt_ff))
			else $error("rise capture missed");
		capture_fall_a: assert property (@(posedge clk_i) // R2
			disable iff (!rstn_i)
			(mode_ff[k][`CCA_B_CAPN] && prev_ff[k] && !sy2_ff[k])
			|=> flag_ff[k])
			else $error("fall capture no flag");
		capture_any_a: assert property (@(posedge clk_i) // R3
			disable iff (!rstn_i)
			((mode_ff[k][`CCA_B_CAPP] && mode_ff[k][`CCA_B_CAPN])
			and (rise_seen(k) or fall_seen(k)))
			|=> flag_ff[k])
			else $error("transition capture no flag");
		pin_sync_a: assert property (@(posedge clk_i) // R5
			disable iff (!rstn_i)
			sy2_ff[k] == $past(module_io_pin_i[k], 2))
			else $error("pin sampling lost");
		capture_copy_a: assert property (@(posedge clk_i) // R6
			disable iff (!rstn_i)
			((decode(mode_ff[k]) == cca_pkg::CCA_CAPTURE
			&& mode_ff[k][`CCA_B_CAPN] && !wr_i) and fall_seen(k))
			|=> caph_ff[k] == $past(cnt_ff[15:8])
			&& capl_ff[k] == $past(cnt_ff[7:0]))
			else $error("capture bytes wrong");
		timer_match_a: assert property (@(posedge clk_i) // R9
			disable iff (!rstn_i)
			(decode(mode_ff[k]) == cca_pkg::CCA_TIMER && run_ff
			&& cnt_ff == {caph_ff[k], capl_ff[k]})
			|=> flag_ff[k])
			else $error("timer flag missing");
		timer_quiet_a: assert property (@(posedge clk_i) // R9
			disable iff (!rstn_i)
			(decode(mode_ff[k]) == cca_pkg::CCA_TIMER
			&& !(run_ff && cnt_ff == {caph_ff[k], capl_ff[k]}))
			|=> !$rose(flag_ff[k]))
			else $error("timer flag without match");
		hso_toggle_a: assert property (@(posedge clk_i) // R10
			disable iff (!rstn_i)
			(decode(mode_ff[k]) == cca_pkg::CCA_HSO && run_ff
			&& cnt_ff == {caph_ff[k], capl_ff[k]})
			|=> module_io_pin_o[k] != $past(pin_ff[k]))
			else $error("hso no toggle");
		hso_hold_a: assert property (@(posedge clk_i) // R10
			disable iff (!rstn_i)
			(decode(mode_ff[k]) == cca_pkg::CCA_HSO
			&& !(run_ff && cnt_ff == {caph_ff[k], capl_ff[k]}))
			|=> $stable(module_io_pin_o[k]))
			else $error("hso toggle without match");
		pwm_level_a: assert property (@(posedge clk_i) // R11
			disable iff (!rstn_i)
			(decode(mode_ff[k]) == cca_pkg::CCA_PWM)
			|=> module_io_pin_oe_o[k] && module_io_pin_o[k]
			== ($past(cnt_ff[7:0]) >= $past(pwmref_ff[k])))
			else $error("pwm level wrong");
		pwm_reload_a: assert property (@(posedge clk_i) // R11
			disable iff (!rstn_i)
			(decode(mode_ff[k]) == cca_pkg::CCA_PWM && run_ff
			&& cnt_ff[7:0] == `CCA_PWM_WRAP)
			|=> pwmref_ff[k] == $past(caph_ff[k]))
			else $error("pwm duty not reloaded");
		flag_sticky_a: assert property (@(posedge clk_i) // R14
			disable iff (!rstn_i)
			$fell(flag_ff[k]) |-> $past(wr_i
			&& addr_i == `CCA_OFF_FLAGS && wdata_i[k]))
			else $error("flag cleared by hw");
		idle_quiet_a: assert property (@(posedge clk_i) // R15
			disable iff (!rstn_i)
			(mode_ff[k] == `CCA_MODE_RST
			&& !(wr_i && addr_i == `CCA_OFF_CAPL + 12'(k))
			&& !(wr_i && addr_i == `CCA_OFF_CAPH + 12'(k)))
			|=> $stable(capl_ff[k]) && !$rose(flag_ff[k]))
			else $error("idle module active");
		idle_drive_a: assert property (@(posedge clk_i) // R15
			disable iff (!rstn_i)
			mode_ff[k] == `CCA_MODE_RST |=> !module_io_pin_oe_o[k])
			else $error("idle module drives pin");
		mode_reserved_a: assert property (@(posedge clk_i) // R16
			disable iff (!rstn_i)
			!mode_ff[k][`CCA_B_RSVD])
			else $error("reserved mode bit set");
	end
endmodule

// ### tb_counter_array_capture_compare.sv
// self-checking bench for the capture/compare array
`timescale 1ns/10ps
`include "cca_consts.svh"
module tb_counter_array_capture_compare;
	logic clk_i = 0;
	logic rstn_i = 0;
	logic wr_i = 0;
	logic rd_i = 0;
	logic rd_d = 0;
	logic [11:0] addr_i = '0;
	logic [7:0] wdata_i = '0;
	logic [7:0] rdata_o;
	logic [7:0] md;
	logic [7:0] r;
	logic [2:0] pin_i;
	logic [2:0] pin_o;
	logic [2:0] oe_o;
	logic irq_o;
	logic [15:0] v;
	logic [15:0] w;
	logic [7:0] exp_q[$];
	logic [7:0] mode_tab [3] = '{8'h21, 8'h10, 8'h31};
	int fails = 0;
	int check_count = 0;
	always #4 clk_i = ~clk_i;
	cca_top i_dut(.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.module_io_pin_i(pin_i), .module_io_pin_o(pin_o),
		.module_io_pin_oe_o(oe_o), .irq_o(irq_o));
	cca_pin_model i_pin(.clk_i(clk_i), .oe_i(oe_o), .drv_i(pin_o),
		.pin_o(pin_i));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge clk_i) begin
		if (rd_d)
			chk(rdata_o, exp_q.pop_front());
		rd_d <= rd_i;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic setcnt(input logic [15:0] c);
		wr(`CCA_OFF_CNTL, c[7:0]);
		wr(`CCA_OFF_CNTH, c[15:8]);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		final_report();
	end
	initial begin
		void'($urandom(85));
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		for (int m = 0; m < 3; m++)
			rd(`CCA_OFF_MODE1 + 12'(m), `CCA_MODE_RST);
		$display("test reset done");
		// counter held still so the captured value is known
		for (int m = 0; m < 3; m++) begin
			md = mode_tab[m];
			v = 16'($urandom());
			w = 16'($urandom());
			wr(`CCA_OFF_MODE1 + 12'(m), md);
			rd(`CCA_OFF_MODE1 + 12'(m), md);
			setcnt(v);
			i_pin.set_pin(m, 1'b1);
			wait_n(6);
			rd(`CCA_OFF_FLAGS, {5'h0, 3'(md[5]) << m});
			setcnt(w);
			i_pin.set_pin(m, 1'b0);
			wait_n(6);
			rd(`CCA_OFF_CAPL + 12'(m), md[4] ? w[7:0] : v[7:0]);
			rd(`CCA_OFF_CAPH + 12'(m), md[4] ? w[15:8] : v[15:8]);
			rd(`CCA_OFF_FLAGS, 8'(1 << m));
			chk({7'h0, irq_o}, {7'h0, md[0]});
			wr(`CCA_OFF_FLAGS, 8'h07);
			wait_n(2);
			rd(`CCA_OFF_FLAGS, 8'h00);
			chk({7'h0, irq_o}, 8'h00);
			$display("test capture %0d done", m);
		end
		wr(`CCA_OFF_MODE1, 8'h00);
		i_pin.set_pin(0, 1'b1);
		wait_n(6);
		rd(`CCA_OFF_FLAGS, 8'h00);
		chk({5'h0, oe_o}, 8'h00);
		$display("test idle done");
		v = 16'($urandom());
		w = v + 16'h0004;
		setcnt(v);
		for (int m = 1; m < 3; m++) begin
			wr(`CCA_OFF_CAPL + 12'(m), w[7:0]);
			wr(`CCA_OFF_CAPH + 12'(m), w[15:8]);
		end
		wr(`CCA_OFF_MODE2, 8'h49);
		wr(`CCA_OFF_MODE3, 8'h4C);
		wr(`CCA_OFF_CTRL, 8'h40);
		wait_n(20);
		wr(`CCA_OFF_CTRL, 8'h00);
		rd(`CCA_OFF_FLAGS, 8'h06);
		chk({7'h0, irq_o}, 8'h01);
		chk({7'h0, pin_o[2]}, 8'h01);
		chk({7'h0, oe_o[2]}, 8'h01);
		$display("test compare done");
		// duty value kept below FE so the reload to FF shows on the pin
		r = 8'($urandom()) & 8'h7F | 8'h01;
		wr(`CCA_OFF_CAPL, r);
		wr(`CCA_OFF_CAPH, r);
		wr(`CCA_OFF_MODE1, 8'h42);
		wr(`CCA_OFF_CNTL, r - 8'h01);
		wait_n(2);
		chk({7'h0, pin_o[0]}, 8'h00);
		chk({7'h0, oe_o[0]}, 8'h01);
		wr(`CCA_OFF_CNTL, r);
		wait_n(2);
		chk({7'h0, pin_o[0]}, 8'h01);
		wr(`CCA_OFF_CAPH, 8'hFF);
		wr(`CCA_OFF_CNTL, 8'hFE);
		wr(`CCA_OFF_CTRL, 8'h40);
		wr(`CCA_OFF_CTRL, 8'h00);
		wr(`CCA_OFF_CNTL, 8'hFE);
		wait_n(2);
		chk({7'h0, pin_o[0]}, 8'h00);
		$display("test pwm done");
		wait_n(3);
		final_report();
	end
endmodule
